// ==== mbcl_pkg.sv ====
package mbcl_pkg;
    // ****************************************
    // command encoding {cs_n, ras_n, cas_n, we_n}
    // ****************************************
    localparam logic [3:0] CMD_ACT  = 4'h3;
    localparam logic [3:0] CMD_RD   = 4'h5;
    localparam logic [3:0] CMD_WR   = 4'h4;
    localparam logic [3:0] CMD_PRE  = 4'h2;
    localparam logic [3:0] CMD_REF  = 4'h1;
    localparam logic [3:0] CMD_MRS  = 4'h0;
    localparam logic [3:0] CMD_NOP  = 4'h7;

    // ****************************************
    // sizes and defaults
    // ****************************************
    localparam int NUM_BANKS   = 8;
    localparam int BANK_W      = 3;
    localparam int CNT_W       = 8;
    localparam int TURN_CLKS   = 2;
    localparam int MIN_OTHER   = 1;
    localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'h0,
        ST_ACTG  = 3'h1,
        ST_ACTV  = 3'h3,
        ST_ACCS  = 3'h2,
        ST_APRE  = 3'h6,
        ST_PREG  = 3'h4
    } bank_state_e;

    typedef struct packed {
        logic              cke;
        logic              cs_n;
        logic              ras_n;
        logic              cas_n;
        logic              we_n;
        logic [BANK_W-1:0] bank;
        logic              auto_pre;
    } cmd_s;

    typedef struct packed {
        logic [CNT_W-1:0] read_latency;
        logic [CNT_W-1:0] write_latency;
        logic [CNT_W-1:0] burst_length;
        logic [CNT_W-1:0] write_recovery_time;
        logic [CNT_W-1:0] write_to_read_turnaround;
        logic [CNT_W-1:0] precharge_period;
        logic [CNT_W-1:0] activate_to_access_delay;
    } timing_s;

    typedef struct packed {
        logic cmd_valid;
        logic illegal;
        logic too_early;
        logic all_idle;
    } verdict_s;
endpackage : mbcl_pkg

// ==== multibank_command_legality.sv ====
`timescale 1ns/1ps
// Operation
// RULE1 - decode act, read, write, precharge from strobes
// RULE2 - checks only with cke high both edges
// RULE3 - bank idle after precharge period, active after delay
// RULE4 - other-bank commands allowed during a burst
// RULE5 - controller masks write data on read interrupt; not modelled, there are no data pins
// RULE6 - read autoprecharge splits at earliest precharge
// RULE7 - write autoprecharge precharge starts after recovery
// RULE8 - other banks usable in precharge, no collision
// RULE9 - refresh and mode load need all idle
// RULE10 - other combinations flagged illegal
// RULE11 - write-ap to read waits wl+bl/2+turnaround
// RULE12 - write-ap to write waits bl/2
// RULE13 - read-ap to read waits bl/2
// RULE14 - read-ap to write waits rl+bl/2+2-wl
// RULE15 - precharge or activate after one clock
// RULE16 - read latency given in whole clocks
// RULE17 - write data two clocks after read data
// RULE18 - cke held high through bursts; not checked, cke is only sampled for each command
// RULE19 - timings supplied as configuration in clocks
module multibank_command_legality import mbcl_pkg::*; #(
    parameter int BANKS = NUM_BANKS
) (
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    // command pins and configuration
    input  wire cmd_s        cmd_pins,
    input  wire timing_s     timing,                          // RULE19
    // verdict
    output logic             cmd_valid,
    output logic             illegal,
    output logic             too_early,
    output logic             all_idle,
    output bank_state_e      bank_state [BANKS]
);
    initial begin
        if (BANKS != NUM_BANKS) $error("bank count must be eight");
    end

    // ****************************************
    // pin synchronisers
    // ****************************************
    cmd_s sync1, sync2, prev;
    cmd_s next_sync1, next_sync2, next_prev;
    always_comb begin
        next_sync1 = cmd_pins;
        next_sync2 = sync1;
        next_prev  = sync2;
    end
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1 <= '1;
            sync2 <= '1;
            prev  <= '1;
        end else begin
            sync1 <= next_sync1;
            sync2 <= next_sync2;
            prev  <= next_prev;
        end
    end

    function automatic logic [3:0] code(input cmd_s c);
        code = {c.cs_n, c.ras_n, c.cas_n, c.we_n};
    endfunction : code

    function automatic logic [CNT_W-1:0] half(input logic [CNT_W-1:0] b);
        half = {1'b0, b[CNT_W-1:1]};
    endfunction : half

    // ****************************************
    // decode and cross-bank windows
    // ****************************************
    logic [3:0] c;
    logic       enabled, is_act, is_rd, is_wr, is_pre, is_ref, is_mrs;
    logic [CNT_W-1:0] rd_gap, wr_gap, oth_gap, t_acc;
    logic [CNT_W-1:0] w_rd, w_wr, r_rd, r_wr;
    logic [BANK_W-1:0] ap_bank;
    logic ap_live, ap_write;
    logic [CNT_W-1:0] next_rd_gap, next_wr_gap, next_oth_gap;
    logic [BANK_W-1:0] next_ap_bank;
    logic next_ap_live, next_ap_write;

    always_comb begin
        c       = code(sync2);
        enabled = prev.cke && sync2.cke;                          // RULE2
        is_act  = enabled && c == CMD_ACT;                        // RULE1
        is_rd   = enabled && c == CMD_RD;                         // RULE1
        is_wr   = enabled && c == CMD_WR;                         // RULE1
        is_pre  = enabled && c == CMD_PRE;                        // RULE1
        is_ref  = enabled && c == CMD_REF;
        is_mrs  = enabled && c == CMD_MRS;
        // latencies arrive in whole clocks already
        w_rd = CNT_W'(timing.write_latency + half(timing.burst_length)
               + timing.write_to_read_turnaround);                // RULE11
        w_wr = half(timing.burst_length);                         // RULE12
        r_rd = half(timing.burst_length);                         // RULE13
        r_wr = CNT_W'(timing.read_latency + half(timing.burst_length)
               + CNT_W'(TURN_CLKS) - timing.write_latency);     // RULE14 RULE16 RULE17
        next_rd_gap  = (rd_gap  != CNT_ZERO) ? rd_gap  - 8'h01 : rd_gap;
        next_wr_gap  = (wr_gap  != CNT_ZERO) ? wr_gap  - 8'h01 : wr_gap;
        next_oth_gap = (oth_gap != CNT_ZERO) ? oth_gap - 8'h01 : oth_gap;
        next_ap_bank  = ap_bank;
        next_ap_live  = ap_live && (rd_gap | wr_gap | oth_gap) != CNT_ZERO;
        next_ap_write = ap_write;
        if ((is_rd || is_wr) && sync2.auto_pre) begin
            next_ap_bank  = sync2.bank;
            next_ap_live  = 1'b1;
            next_ap_write = is_wr;
            // counts reach zero on the first legal edge
            next_rd_gap   = (is_wr ? w_rd : r_rd) - 8'h01;
            next_wr_gap   = (is_wr ? w_wr : r_wr) - 8'h01;
            next_oth_gap  = CNT_W'(MIN_OTHER) - 8'h01;            // RULE15
        end
    end
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_gap   <= CNT_ZERO;
            wr_gap   <= CNT_ZERO;
            oth_gap  <= CNT_ZERO;
            ap_bank  <= '0;
            ap_live  <= 1'b0;
            ap_write <= 1'b0;
        end else begin
            rd_gap   <= next_rd_gap;
            wr_gap   <= next_wr_gap;
            oth_gap  <= next_oth_gap;
            ap_bank  <= next_ap_bank;
            ap_live  <= next_ap_live;
            ap_write <= next_ap_write;
        end
    end

    // ****************************************
    // per-bank state machines
    // ****************************************
    bank_state_e      st      [BANKS];
    bank_state_e      next_st [BANKS];
    logic [CNT_W-1:0] tmr      [BANKS];
    logic [CNT_W-1:0] next_tmr [BANKS];
    logic [BANKS-1:0] bank_ok, idle_vec;

    always_comb begin
        for (int b = 0; b < BANKS; b++) begin
            logic hit;
            hit = sync2.bank == BANK_W'(b);
            next_st[b]  = st[b];
            next_tmr[b] = (tmr[b] != CNT_ZERO) ? tmr[b] - 8'h01 : tmr[b];
            idle_vec[b] = st[b] == ST_IDLE;
            bank_ok[b]  = 1'b1;
            // write recovery measured as if no auto precharge
            t_acc = CNT_W'(timing.write_latency + half(timing.burst_length)
                    + timing.write_recovery_time);                 // RULE7
            case (st[b])
                ST_IDLE: begin
                    bank_ok[b] = !(hit && (is_rd || is_wr || is_pre));
                    if (hit && is_act) begin
                        next_st[b]  = ST_ACTG;
                        next_tmr[b] = timing.activate_to_access_delay;
                    end
                end
                ST_ACTG: begin
                    bank_ok[b] = !(hit && (is_act || is_rd || is_wr));
                    if (tmr[b] <= 8'h01) next_st[b] = ST_ACTV;     // RULE3
                end
                ST_ACTV, ST_ACCS: begin
                    bank_ok[b] = !(hit && is_act);                 // RULE4
                    if (st[b] == ST_ACCS && tmr[b] <= 8'h01)
                        next_st[b] = ST_ACTV;
                    if (hit && (is_rd || is_wr)) begin
                        next_st[b]  = sync2.auto_pre ? ST_APRE : ST_ACCS;
                        // read: earliest explicit precharge is bl/2 on
                        next_tmr[b] = is_wr ? t_acc
                                      : half(timing.burst_length); // RULE6
                    end
                    if (hit && is_pre) begin
                        next_st[b]  = ST_PREG;
                        next_tmr[b] = timing.precharge_period;
                    end
                end
                ST_APRE: begin
                    bank_ok[b] = !hit || !(is_act || is_rd || is_wr || is_pre);
                    if (tmr[b] <= 8'h01) begin
                        next_st[b]  = ST_PREG;
                        next_tmr[b] = timing.precharge_period;
                    end
                end
                ST_PREG: begin
                    bank_ok[b] = !(hit && (is_act || is_rd || is_wr));
                    if (tmr[b] <= 8'h01) next_st[b] = ST_IDLE;     // RULE3
                end
                default: next_st[b] = ST_IDLE;
            endcase
        end
    end
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int b = 0; b < BANKS; b++) begin
                st[b]  <= ST_IDLE;
                tmr[b] <= CNT_ZERO;
            end
        end else begin
            for (int b = 0; b < BANKS; b++) begin
                st[b]  <= next_st[b];
                tmr[b] <= next_tmr[b];
            end
        end
    end

    // ****************************************
    // verdict
    // ****************************************
    logic other_bank;
    verdict_s v, next_v;
    always_comb begin
        other_bank = ap_live && sync2.bank != ap_bank;
        next_v.all_idle  = &idle_vec;
        next_v.cmd_valid = is_act || is_rd || is_wr || is_pre
                           || is_ref || is_mrs;
        next_v.illegal   = (!(&bank_ok))
                           || ((is_ref || is_mrs) && !(&idle_vec)) // RULE9
                           || (enabled && c[3] == 1'b0
                               && c == 4'h6);                     // RULE10
        next_v.too_early = other_bank
                           && ((is_rd && rd_gap != CNT_ZERO)       // RULE11 RULE13
                           || (is_wr && wr_gap != CNT_ZERO)        // RULE12 RULE14
                           || ((is_act || is_pre)
                               && oth_gap != CNT_ZERO));           // RULE15 RULE8
    end
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) v <= '0;
        else        v <= next_v;
    end
    assign cmd_valid = v.cmd_valid;
    assign illegal   = v.illegal;
    assign too_early = v.too_early;
    assign all_idle  = v.all_idle;
    assign bank_state = st;

    // ****************************************
    // checks
    // ****************************************
    sequence wap_issued;
        is_wr && sync2.auto_pre && w_rd > 8'h01;
    endsequence
    read_gap_set_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        wap_issued |=> rd_gap == $past(w_rd) - 8'h01)                // RULE11
        else $error("read gap not loaded after write ap");
    idle_ref_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (is_ref && !(&idle_vec)) |=> illegal)                         // RULE9
        else $error("refresh with busy bank not flagged");
    no_cke_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        !prev.cke |=> !cmd_valid)                                     // RULE2
        else $error("command taken without cke");
    act_decode_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (enabled && c == CMD_ACT) |=> cmd_valid)                      // RULE1
        else $error("activate not decoded");
    pre_idle_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (st[0] == ST_PREG && tmr[0] == 8'h01) |=> st[0] == ST_IDLE)   // RULE3
        else $error("bank not idle after precharge period");
    other_gap_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (is_rd && sync2.auto_pre) |=> oth_gap == CNT_ZERO)            // RULE15
        else $error("one clock gap not applied");
    burst_other_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (st[0] == ST_ACCS && sync2.bank != 3'h0 && is_act
         && st[sync2.bank] == ST_IDLE && !too_early) |=> !illegal)   // RULE4
        else $error("other bank blocked during burst");
    rap_split_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (st[0] == ST_APRE && tmr[0] == 8'h01) |=> st[0] == ST_PREG)   // RULE6 RULE7
        else $error("auto precharge period not entered");
endmodule : multibank_command_legality

// ==== mbcl_ctrl_model.sv ====
`timescale 1ns/1ps
// ****************************************
// controller side of the command pins
// ****************************************
module mbcl_ctrl_model import mbcl_pkg::*; (
    // clock and reset
    input  wire logic core_clk,
    input  wire logic rst_n,
    // request from the bench, pins to the block
    input  wire cmd_s req,
    output cmd_s      cmd_pins
);
    logic toggle;

    // deselected cycles scramble ras_n, cas_n and bank so their stale levels never pass; we_n is passed through
    always @(negedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            toggle   <= 1'b0;
            cmd_pins <= '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 3'h5, 1'b0};
        end else begin
            toggle <= ~toggle;
            // no data pins here: masking and bus turnaround are not modelled, and
            // the bench drives early and illegal commands on purpose
            cmd_pins <= req;
            if (req.cs_n) begin
                cmd_pins.ras_n <= toggle;
                cmd_pins.cas_n <= ~toggle;
                cmd_pins.bank  <= {3{toggle}};
            end
        end
    end
endmodule : mbcl_ctrl_model

// ==== multibank_command_legality_test.sv ====
`timescale 1ns/1ps
module multibank_command_legality_test import mbcl_pkg::*; ;
    logic        core_clk;
    logic        rst_n;
    cmd_s        req;
    cmd_s        cmd_pins;
    timing_s     timing;
    logic        cmd_valid;
    logic        illegal;
    logic        too_early;
    logic        all_idle;
    bank_state_e bank_st [NUM_BANKS];
    int          err_count;
    int          checks_done;
    int          cycles;

    mbcl_ctrl_model ctrl (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .req      (req),
        .cmd_pins (cmd_pins)
    );

    multibank_command_legality dut (
        .core_clk   (core_clk),
        .rst_n      (rst_n),
        .cmd_pins   (cmd_pins),
        .timing     (timing),
        .cmd_valid  (cmd_valid),
        .illegal    (illegal),
        .too_early  (too_early),
        .all_idle   (all_idle),
        .bank_state (bank_st)
    );

    // ****************************************
    // helpers
    // ****************************************
    task close_out;
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : close_out

    task chk(input string nm, input logic [3:0] exp, input logic [3:0] got);
        checks_done++;
        if (got !== exp) begin
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
            err_count++;
        end
    endtask : chk

    // one command for one cycle, then deselect
    task send(input logic [3:0] c, input logic [2:0] b, input logic ap,
              input logic ke = 1'b1);
        @(posedge core_clk);
        #1 req = '{ke, c[3], c[2], c[1], c[0], b, ap};
        @(posedge core_clk);
        #1 req = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 3'h0, 1'b0};
    endtask : send

    // two commands on adjacent cycles, then deselect
    task send2(input logic [3:0] c1, input logic [2:0] b1, input logic a1,
               input logic [3:0] c2, input logic [2:0] b2, input logic a2);
        @(posedge core_clk);
        #1 req = '{1'b1, c1[3], c1[2], c1[1], c1[0], b1, a1};
        @(posedge core_clk);
        #1 req = '{1'b1, c2[3], c2[2], c2[1], c2[0], b2, a2};
        @(posedge core_clk);
        #1 req = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 3'h0, 1'b0};
    endtask : send2

    // verdict of the last command stands one cycle, two edges on
    task answer;
        repeat (2) @(posedge core_clk);
        #1;
    endtask : answer

    task idle(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : idle

    // ****************************************
    // scenarios
    // ****************************************
    task t_reset;
        idle(2);
        chk("all_idle", 4'h1, all_idle);
        chk("bank0", ST_IDLE, bank_st[0]);
    endtask : t_reset

    task t_activate;
        send(CMD_ACT, 3'h1, 1'b0);
        answer();
        chk("act valid", 4'h1, cmd_valid);
        chk("bank1 actg", ST_ACTG, bank_st[1]);
        send(CMD_ACT, 3'h2, 1'b0);
        send(CMD_ACT, 3'h3, 1'b0);
        answer();
        chk("act other", 4'h1, cmd_valid);
        idle(6);
        chk("bank1 actv", ST_ACTV, bank_st[1]);
        chk("all_idle busy", 4'h0, all_idle);
    endtask : t_activate

    task t_read_ap;
        send2(CMD_RD, 3'h1, 1'b1, CMD_RD, 3'h2, 1'b0);
        answer();
        chk("rd after rdap", 4'h1, too_early);
        idle(20);
        chk("bank1 back idle", ST_IDLE, bank_st[1]);
    endtask : t_read_ap

    task t_write_ap;
        send2(CMD_WR, 3'h2, 1'b1, CMD_RD, 3'h3, 1'b0);
        answer();
        chk("rd after wrap", 4'h1, too_early);
        idle(25);
        chk("bank2 back idle", ST_IDLE, bank_st[2]);
    endtask : t_write_ap

    task t_ap_to_act;
        send2(CMD_RD, 3'h3, 1'b1, CMD_ACT, 3'h4, 1'b0);
        answer();
        chk("act after rdap", 4'h0, too_early);
        chk("act after valid", 4'h1, cmd_valid);
        idle(20);
    endtask : t_ap_to_act

    task t_illegal;
        send(CMD_RD, 3'h5, 1'b0);
        answer();
        chk("rd idle bank", 4'h1, illegal);
        send(4'h6, 3'h5, 1'b0);
        answer();
        chk("unused code", 4'h1, illegal);
    endtask : t_illegal

    task t_refresh;
        send(CMD_REF, 3'h0, 1'b0);
        answer();
        chk("ref busy", 4'h1, illegal);
        send(CMD_PRE, 3'h4, 1'b0);
        idle(12);
        chk("all_idle again", 4'h1, all_idle);
        send(CMD_REF, 3'h0, 1'b0);
        answer();
        chk("ref idle ok", 4'h1, cmd_valid);
        chk("ref idle legal", 4'h0, illegal);
        idle(10);
    endtask : t_refresh

    task t_cke_low;
        send(CMD_ACT, 3'h6, 1'b0, 1'b0);
        answer();
        chk("cke low", 4'h0, cmd_valid);
        chk("bank6 idle", ST_IDLE, bank_st[6]);
    endtask : t_cke_low

    task t_write_gaps;
        send(CMD_ACT, 3'h5, 1'b0);
        send(CMD_ACT, 3'h6, 1'b0);
        idle(6);
        send2(CMD_RD, 3'h5, 1'b1, CMD_WR, 3'h6, 1'b0);
        answer();
        chk("wr after rdap", 4'h1, too_early);
        idle(20);
        send(CMD_ACT, 3'h5, 1'b0);
        idle(6);
        send2(CMD_WR, 3'h6, 1'b1, CMD_WR, 3'h5, 1'b0);
        answer();
        chk("wr after wrap", 4'h1, too_early);
        idle(25);
    endtask : t_write_gaps

    // ****************************************
    // clock, timeout and main sequence
    // ****************************************
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    // the whole run needs well under a thousand cycles
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 3000) begin
            err_count++;
            close_out();
        end
    end

    initial begin
        err_count   = 0;
        checks_done = 0;
        cycles      = 0;
        rst_n       = 1'b0;
        req         = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 3'h0, 1'b0};
        timing      = '{8'h04, 8'h02, 8'h04, 8'h03, 8'h02, 8'h03, 8'h03};
        repeat (3) @(posedge core_clk);
        @(negedge core_clk) rst_n = 1'b1;
        t_reset();
        t_activate();
        t_read_ap();
        t_write_ap();
        t_ap_to_act();
        t_illegal();
        t_refresh();
        t_cke_low();
        t_write_gaps();
        close_out();
    end
endmodule : multibank_command_legality_test
